// >>> logic/dma_event_pkg.sv
/*
  package for the dma channel event flag block: register offsets, field
  positions, widths and reset values.
  assumes a 32-bit axi4-lite register bus and 16-bit channel pointers.
*/
package dma_event_pkg;
  localparam int unsigned ptr_w = 16;
  localparam int unsigned nflags = 8;
  // register byte addresses
  localparam logic [7:0] addr_int_ctrl = 8'h00;
  localparam logic [7:0] addr_src_size = 8'h04;
  localparam logic [7:0] addr_dst_size = 8'h08;
  localparam logic [7:0] addr_cell_size = 8'h0C;
  localparam logic [7:0] addr_abort_sel = 8'h10;
  localparam logic [7:0] addr_status = 8'h14;
  // field layout of the interrupt control and abort select registers
  localparam int unsigned flag_lsb = 0;
  localparam int unsigned ie_lsb = 16;
  localparam int unsigned abort_sel_w = 8;
  // flag bit positions
  localparam int unsigned bit_addr_err = 0;
  localparam int unsigned bit_abort = 1;
  localparam int unsigned bit_cell = 2;
  localparam int unsigned bit_block = 3;
  localparam int unsigned bit_dst_half = 4;
  localparam int unsigned bit_dst_done = 5;
  localparam int unsigned bit_src_half = 6;
  localparam int unsigned bit_src_done = 7;
  // reset values and response codes
  localparam logic [7:0] flags_rst = 8'h00;
  localparam logic [15:0] size_rst = 16'h0000;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// >>> logic/ptr_event_detect.sv
/*
  one pointer event detector: flags the cycle in which a pointer first
  equals a target value.
  assumes the pointer and target are on the aclk domain.
*/
`timescale 1ns/1ps
module ptr_event_detect (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // compare
  input wire logic [dma_event_pkg::ptr_w-1:0] ptr,
  input wire logic [dma_event_pkg::ptr_w-1:0] target,
  input wire logic armed,
  // event
  output logic hit
);
  logic matched;

  // level match remembered so a held match fires once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      matched <= 1'b0;
    end else begin
      matched <= armed && (ptr == target);
    end
  end

  assign hit = armed && (ptr == target) && !matched;
endmodule

// >>> logic/dma_channel_event_flags.sv
/*
  dma channel event flags: sticky event flags, matching enables and the
  channel interrupt request, with sizes and abort select over axi4-lite.
  assumes the transfer engine drives pointers and byte pulses on aclk.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dma_channel_event_flags (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transfer engine status
  input wire logic [dma_event_pkg::ptr_w-1:0] source_pointer,
  input wire logic [dma_event_pkg::ptr_w-1:0] destination_pointer,
  input wire logic xfer_active,
  input wire logic byte_moved,
  input wire logic pattern_match,
  input wire logic addr_invalid,
  input wire logic [255:0] irq_lines,
  // toward engine and interrupt controller
  output logic xfer_abort,
  output logic channel_irq
);
  logic [7:0] flags;
  logic [7:0] enables;
  logic [7:0] set_ev;
  logic [7:0] clr_mask;
  logic [15:0] source_size;
  logic [15:0] destination_size;
  logic [15:0] cell_size;
  logic [7:0] abort_trigger_select;
  logic abort_en;
  logic [15:0] cell_count;
  logic [15:0] block_count;
  logic [15:0] block_target;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic hit_sd, hit_sh, hit_dd, hit_dh;
  logic abort_hit;

  // half of a size, rounded down
  function automatic logic [15:0] half_of(input logic [15:0] v);
    half_of = {1'b0, v[15:1]};
  endfunction

  // byte-lane merge of a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  ptr_event_detect u_src_done (.aclk(aclk), .aresetn(aresetn),
    .ptr(source_pointer), .target(source_size), .armed(xfer_active),
    .hit(hit_sd));
  ptr_event_detect u_src_half (.aclk(aclk), .aresetn(aresetn),
    .ptr(source_pointer), .target(half_of(source_size)),
    .armed(xfer_active), .hit(hit_sh));
  ptr_event_detect u_dst_done (.aclk(aclk), .aresetn(aresetn),
    .ptr(destination_pointer), .target(destination_size),
    .armed(xfer_active), .hit(hit_dd));
  ptr_event_detect u_dst_half (.aclk(aclk), .aresetn(aresetn),
    .ptr(destination_pointer), .target(half_of(destination_size)),
    .armed(xfer_active), .hit(hit_dh));

  // block target is the larger of the two sizes
  assign block_target = (source_size > destination_size) ?
    source_size : destination_size;

  always_ff @(posedge aclk) begin
    if (!aresetn || !xfer_active) begin
      cell_count <= dma_event_pkg::size_rst;
    end else if (byte_moved) begin
      cell_count <= (cell_count + 16'h0001 >= cell_size) ?
        16'h0000 : cell_count + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !xfer_active) begin
      block_count <= dma_event_pkg::size_rst;
    end else if (byte_moved) begin
      block_count <= block_count + 16'h0001;
    end
  end

  assign abort_hit = abort_en && xfer_active &&
    irq_lines[abort_trigger_select];
  assign xfer_abort = abort_hit;

  // event vector in flag order
  always_comb begin
    set_ev = 8'h00;
    set_ev[dma_event_pkg::bit_src_done] = hit_sd;
    set_ev[dma_event_pkg::bit_src_half] = hit_sh;
    set_ev[dma_event_pkg::bit_dst_done] = hit_dd;
    set_ev[dma_event_pkg::bit_dst_half] = hit_dh;
    set_ev[dma_event_pkg::bit_block] = pattern_match || (xfer_active &&
      byte_moved && (block_count + 16'h0001 == block_target));
    set_ev[dma_event_pkg::bit_cell] = xfer_active && byte_moved &&
      (cell_count + 16'h0001 >= cell_size);
    set_ev[dma_event_pkg::bit_abort] = abort_hit;
    set_ev[dma_event_pkg::bit_addr_err] = addr_invalid;
  end

  // write channel capture, address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dma_event_pkg::resp_okay;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr[7:2] > dma_event_pkg::addr_status[7:2]) begin
        s_axi_bresp <= dma_event_pkg::resp_slverr;
      end else begin
        s_axi_bresp <= dma_event_pkg::resp_okay;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // software clear of flags: write zero to bit clears it
  always_comb begin
    clr_mask = 8'h00;
    if (wr_go && aw_addr[7:2] == dma_event_pkg::addr_int_ctrl[7:2] &&
        w_strb[0]) begin
      clr_mask = ~w_data[7:0];
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= dma_event_pkg::flags_rst;
    end else begin
      flags <= (flags & ~clr_mask) | set_ev;
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enables <= dma_event_pkg::flags_rst;
      source_size <= dma_event_pkg::size_rst;
      destination_size <= dma_event_pkg::size_rst;
      cell_size <= dma_event_pkg::size_rst;
      abort_trigger_select <= 8'h00;
      abort_en <= 1'b0;
    end else if (wr_go) begin
      if (aw_addr[7:2] == dma_event_pkg::addr_int_ctrl[7:2]) begin
        if (w_strb[2]) begin
          enables <= w_data[dma_event_pkg::ie_lsb +: 8];
        end
      end else if (aw_addr[7:2] == dma_event_pkg::addr_src_size[7:2]) begin
        source_size <= merge16(source_size, w_data, w_strb);
      end else if (aw_addr[7:2] == dma_event_pkg::addr_dst_size[7:2]) begin
        destination_size <= merge16(destination_size, w_data, w_strb);
      end else if (aw_addr[7:2] == dma_event_pkg::addr_cell_size[7:2]) begin
        cell_size <= merge16(cell_size, w_data, w_strb);
      end else if (aw_addr[7:2] == dma_event_pkg::addr_abort_sel[7:2]) begin
        if (w_strb[0]) begin
          abort_trigger_select <= w_data[7:0];
        end
        if (w_strb[1]) begin
          abort_en <= w_data[8];
        end
      end
    end
  end

  assign channel_irq = |(flags & enables);

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= dma_event_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= dma_event_pkg::resp_okay;
      if (s_axi_araddr[7:2] == dma_event_pkg::addr_int_ctrl[7:2]) begin
        s_axi_rdata <= {8'h00, enables, 8'h00, flags};
      end else if (s_axi_araddr[7:2] == dma_event_pkg::addr_src_size[7:2])
          begin
        s_axi_rdata <= {16'h0000, source_size};
      end else if (s_axi_araddr[7:2] == dma_event_pkg::addr_dst_size[7:2])
          begin
        s_axi_rdata <= {16'h0000, destination_size};
      end else if (s_axi_araddr[7:2] == dma_event_pkg::addr_cell_size[7:2])
          begin
        s_axi_rdata <= {16'h0000, cell_size};
      end else if (s_axi_araddr[7:2] == dma_event_pkg::addr_abort_sel[7:2])
          begin
        s_axi_rdata <= {23'h0, abort_en, abort_trigger_select};
      end else if (s_axi_araddr[7:2] == dma_event_pkg::addr_status[7:2])
          begin
        s_axi_rdata <= {30'h0, xfer_active, channel_irq};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= dma_event_pkg::resp_slverr;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> verification/dma_event_flags_asserts.sv
/* assertions on the event flag block ports; assumes the bind below */
`timescale 1ns/1ps
module dma_event_flags_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // engine side and request
  input wire logic xfer_active,
  input wire logic [255:0] irq_lines,
  input wire logic pattern_match,
  input wire logic addr_invalid,
  input wire logic xfer_abort,
  input wire logic channel_irq
);
  logic ev_d;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // some event input was present on the previous edge
  always_ff @(posedge aclk) ev_d <= pattern_match | addr_invalid | xfer_active;
  // a write taken whole, then answered
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_done;
    ##[1:3] s_axi_bvalid;
  endsequence
  property p_wr_resp; s_wr_take |-> s_wr_done; endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write not answered");
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read not answered");
  property p_w_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_busy: assert property (p_w_busy)
    else $error("write taken while answering");
  property p_rsv; s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00; endproperty
  a_rsv: assert property (p_rsv)
    else $error("upper byte not zero");
  property p_irq_rst; $rose(aresetn) |-> !channel_irq; endproperty
  a_irq_rst: assert property (p_irq_rst)
    else $error("request after reset");
  property p_irq_rise; $rose(channel_irq) |-> ev_d || $rose(s_axi_bvalid);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("request without cause");
  property p_irq_fall; $fell(channel_irq) |-> $rose(s_axi_bvalid); endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("request dropped without write");
  // abort only while transferring and with some system line raised
  property p_abort; xfer_abort |-> xfer_active && (|irq_lines);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort while idle");
endmodule
bind dma_channel_event_flags dma_event_flags_asserts u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .xfer_active,
  .irq_lines, .pattern_match, .addr_invalid, .xfer_abort, .channel_irq);

// >>> verification/dma_engine_model.sv
/* transfer engine model; assumes a one-cycle go while idle */
`timescale 1ns/1ps
module dma_engine_model (
  // clock and control
  input wire logic aclk,
  input wire logic go,
  input wire logic slow,
  input wire logic [15:0] len,
  input wire logic xfer_abort,
  // engine status
  output logic [15:0] source_pointer,
  output logic [15:0] destination_pointer,
  output logic xfer_active,
  output logic byte_moved
);
  logic ph;
  // idle before the first transfer
  initial begin
    {ph, xfer_active, byte_moved} = 3'h0;
    source_pointer = 16'h0000;
  end
  assign destination_pointer = source_pointer;
  always @(posedge aclk) begin
    byte_moved <= 1'h0;
    ph <= slow ? !ph : 1'h1;
    if (go && !xfer_active) begin
      xfer_active <= 1'h1;
      source_pointer <= 16'h0000;
    end else if (xfer_active && (xfer_abort || source_pointer == len)) begin
      xfer_active <= 1'h0;
    end else if (xfer_active && ph) begin
      byte_moved <= 1'h1;
      source_pointer <= source_pointer + 16'h0001;
    end
  end
endmodule

// >>> verification/dma_channel_event_flags_tb_top.sv
/* bench for the event flag block; assumes the engine model beside it */
`timescale 1ns/1ps
module dma_channel_event_flags_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, slow;
  logic awready, wready, bvalid, arready, rvalid, act, moved, pm, aerr;
  logic abort, irq;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  logic [7:0] awaddr, araddr, sel;
  logic [15:0] sptr, dptr, len;
  logic [31:0] wdata, rdata, rnd;
  logic [255:0] lines;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_mismatch, compares, n_abort;
  dma_channel_event_flags dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .source_pointer(sptr),
    .destination_pointer(dptr), .xfer_active(act), .byte_moved(moved),
    .pattern_match(pm), .addr_invalid(aerr), .irq_lines(lines),
    .xfer_abort(abort), .channel_irq(irq));
  dma_engine_model eng (.aclk(aclk), .go(go), .slow(slow), .len(len),
    .xfer_abort(abort), .source_pointer(sptr), .destination_pointer(dptr),
    .xfer_active(act), .byte_moved(moved));
  // 100 MHz clock
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic [1:0] g, input logic [1:0] e);
    chk({32'h0, g}, {32'h0, e});
  endtask
  // request level looked at mid-cycle, after flags have settled
  task automatic chk_irq(input logic e);
    @(negedge aclk);
    chk({33'h0, irq}, {33'h0, e});
  endtask
  task automatic end_of_test();
    $display("n_mismatch %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic fail();
    n_mismatch++;
    $display("FAIL %0t wait ran out", $time);
    end_of_test();
  endtask
  // one bus write or read, expectation noted first
  task automatic xfer(input logic we, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    int n;
    logic ta, tw, tr;
    if (we) bq.push_back(r);
    else rq.push_back({d, r});
    @(posedge aclk);
    {awaddr, araddr, wdata, wstrb} <= {a, a, d, s};
    {awvalid, wvalid, bready} <= {3{we}};
    {arvalid, rready} <= {2{!we}};
    n = 0;
    do begin
      @(negedge aclk);
      ta = (awvalid && awready) || (arvalid && arready);
      tw = wvalid && wready;
      tr = we ? bvalid : rvalid;
      @(posedge aclk);
      if (ta) {awvalid, arvalid} <= 2'h0;
      if (tw) wvalid <= 1'h0;
      n++;
    end while (!tr && n < 50);
    {bready, rready} <= 2'h0;
    if (!tr) fail();
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d, 4'hF, dma_event_pkg::resp_okay);
  endtask
  task automatic wc(input logic [31:0] d, input logic [3:0] s);
    xfer(1'h1, dma_event_pkg::addr_int_ctrl, d, s, dma_event_pkg::resp_okay);
  endtask
  task automatic rc(input logic [7:0] en, input logic [7:0] f);
    xfer(1'h0, dma_event_pkg::addr_int_ctrl, {8'h00, en, 8'h00, f}, 4'h0,
      dma_event_pkg::resp_okay);
  endtask
  // one event pulse, then the request level
  task automatic ev(input logic [1:0] k, input logic e);
    @(posedge aclk);
    {pm, aerr} <= k;
    @(posedge aclk);
    {pm, aerr} <= 2'h0;
    chk_irq(e);
  endtask
  // start the engine and wait for it to go idle
  task automatic run();
    int n;
    @(posedge aclk);
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (act && n < 500);
    if (act) fail();
  endtask
  // answers matched against the oldest expectation
  always @(posedge aclk) begin
    // abort cycles seen on the engine side
    if (abort) n_abort++;
    if (rvalid && rready && rq.size() > 0) begin
      chk({rdata, rresp}, rq.pop_front());
    end
    if (bvalid && bready && bq.size() > 0) chk_b(bresp, bq.pop_front());
  end
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go, slow} = 8'h00;
    {pm, aerr, awaddr, araddr, wstrb, wdata, lines, len} = '0;
    {rnd, n_mismatch, compares, n_abort} = {32'h1702, 96'h0};
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rc(8'h00, 8'h00);
    wc(32'hFFFF_FFFF, 4'hF);
    rc(8'hFF, 8'h00);
    chk_irq(1'h0);
    xfer(1'h1, 8'h18, 32'h1, 4'hF, dma_event_pkg::resp_slverr);
    xfer(1'h0, 8'h18, 32'h0, 4'h0, dma_event_pkg::resp_slverr);
    ev(2'h1, 1'h1);
    rc(8'hFF, 8'h01);
    wc(32'h0, 4'h1);
    chk_irq(1'h0);
    ev(2'h2, 1'h1);
    rc(8'hFF, 8'h08);
    wc(32'h0, 4'h1);
    wc(32'h0, 4'h4);
    ev(2'h1, 1'h0);
    rc(8'h00, 8'h01);
    wc(32'h0, 4'h1);
    wc(32'h00FF_0000, 4'h4);
    rnd = lfsr(rnd);
    len = 16'h0004 + {11'h000, rnd[3:0], 1'h0};
    slow <= rnd[4];
    w(dma_event_pkg::addr_src_size, {16'h0000, len});
    w(dma_event_pkg::addr_dst_size, {15'h0000, len, 1'h0});
    w(dma_event_pkg::addr_cell_size, {16'h0000, len});
    run();
    rc(8'hFF, 8'hD4);
    chk(34'(n_abort), 34'h0);
    wc(32'h0, 4'h1);
    // other pacing, destination size equal to source size
    slow <= !rnd[4];
    w(dma_event_pkg::addr_dst_size, {16'h0000, len});
    run();
    rc(8'hFF, 8'hFC);
    wc(32'h0, 4'h1);
    sel = rnd[15:8];
    w(dma_event_pkg::addr_abort_sel, {23'h0, 1'h1, sel});
    @(posedge aclk);
    lines[sel] <= 1'h1;
    run();
    @(posedge aclk);
    lines <= '0;
    rc(8'hFF, 8'h02);
    chk(34'(n_abort), 34'h1);
    ev(2'h1, 1'h1);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rc(8'h00, 8'h00);
    end_of_test();
  end
endmodule
